// file: inc/sdbe_pkg.sv
package sdbe_pkg;
  // link widths
  localparam int DQ_W = 18;
  localparam int BYTE_W = 9;
  localparam int LANE_N = 2;
  localparam int BEAT_N = 4;
  localparam int ADDR_W = 20;
  // storage model: index bits actually held in flip-flops
  localparam int ARR_AW = 6;
  localparam int ARR_DEPTH = 64;
  // protected word: two bytes of one lane plus hidden check bits
  localparam int WORD_W = 18;
  localparam int CHK_W = 5;
  localparam int CW_W = 23;
  localparam int WORD_N = 4;
  // power-up waits, in clock cycles
  localparam int unsigned IMP_WAIT_CYC = 163840;
  localparam int unsigned DLL_LOCK_CYC = 65536;
  localparam int PU_CNT_W = 18;
  // reset values
  localparam logic ECC_OFF_RST = 1'b0;
  localparam logic TOGGLE_RST = 1'b0;

  typedef enum logic [1:0] {
    PU_IMP = 2'b00,
    PU_LOCK = 2'b01,
    PU_DONE = 2'b10
  } sdbe_pu_t;

  typedef logic [BEAT_N-1:0][DQ_W-1:0] sdbe_burst_t;
  typedef logic [BEAT_N-1:0][LANE_N-1:0] sdbe_mask_t;
  typedef logic [WORD_N-1:0][CW_W-1:0] sdbe_entry_t;
  typedef logic [WORD_N-1:0][WORD_W-1:0] sdbe_words_t;
endpackage : sdbe_pkg

// file: inc/sdbe_ecc_if.sv
`timescale 1ns/10ps
interface sdbe_ecc_if;
  // word to encode on the write path
  logic [sdbe_pkg::WORD_W-1:0] wr_data;
  logic [sdbe_pkg::CHK_W-1:0] wr_chk;
  // stored word and check bits on the read path
  logic [sdbe_pkg::WORD_W-1:0] rd_data;
  logic [sdbe_pkg::CHK_W-1:0] rd_chk;
  logic fix_en;
  logic [sdbe_pkg::WORD_W-1:0] rd_fix;

  modport core (
    output wr_data,
    output rd_data,
    output rd_chk,
    output fix_en,
    input wr_chk,
    input rd_fix
  );
  modport coder (
    input wr_data,
    input rd_data,
    input rd_chk,
    input fix_en,
    output wr_chk,
    output rd_fix
  );
endinterface : sdbe_ecc_if

// file: design/sdbe_ecc_word.sv
`timescale 1ns/10ps
module sdbe_ecc_word (
  // coder side of one protected word
  sdbe_ecc_if.coder eb
);
  import sdbe_pkg::*;

  // check bits: xor of codeword positions holding a one (data skips powers of two)
  function automatic logic [CHK_W-1:0] chk_of(input logic [WORD_W-1:0] d);
    logic [CHK_W-1:0] c;
    int k;
    c = '0;
    k = 0;
    for (int p = 1; p <= CW_W; p++) begin
      if ((p & (p - 1)) != 0) begin
        if (d[k]) begin
          c = c ^ CHK_W'(p);
        end
        k++;
      end
    end
    return c;
  endfunction : chk_of

  logic [CHK_W-1:0] syn;
  logic [WORD_W-1:0] fixd;

  // encode path
  assign eb.wr_chk = chk_of(eb.wr_data);

  // syndrome names the flipped position; a check-bit flip leaves data alone, a multi-bit error may flip a wrong data bit
  always_comb begin
    int k;
    k = 0;
    syn = eb.rd_chk ^ chk_of(eb.rd_data);
    fixd = eb.rd_data;
    for (int p = 1; p <= CW_W; p++) begin
      if ((p & (p - 1)) != 0) begin
        if (eb.fix_en && (syn == CHK_W'(p))) begin
          fixd[k] = ~fixd[k];
        end
        k++;
      end
    end
  end

  assign eb.rd_fix = fixd;
endmodule : sdbe_ecc_word

// file: design/sdbe_port.sv
`timescale 1ns/10ps
module sdbe_port #(
  parameter int unsigned IMP_WAIT = sdbe_pkg::IMP_WAIT_CYC,
  parameter int unsigned DLL_WAIT = sdbe_pkg::DLL_LOCK_CYC
) (
  // system clock and reset
  input wire logic clk,
  input wire logic rst,
  // link clocks
  input wire logic k_clk,
  input wire logic kbar_clk,
  // command
  input wire logic [sdbe_pkg::ADDR_W-1:0] sync_address_inputs,
  input wire logic read_sel_n,
  input wire logic write_sel_n,
  // write data
  input wire logic [sdbe_pkg::DQ_W-1:0] write_data_in,
  input wire logic [sdbe_pkg::LANE_N-1:0] byte_write_mask_n,
  // read data
  output logic [sdbe_pkg::DQ_W-1:0] read_data_out,
  output logic read_output_valid,
  output logic echo_clock_out,
  output logic echo_clock_out_n,
  // control and status
  input wire logic dll_off_n,
  output logic dll_enabled,
  output logic ecc_active,
  output logic powerup_done
);
  import sdbe_pkg::*;

  // reset synchronisers for the two link edges
  logic krst_s1_r, krst_r, kbrst_s1_r, kbrst_r;
  // command state
  logic rd_prev_r, rd_prev_nxt, wr_prev_r, wr_prev_nxt, rd_acc, wr_acc;
  logic rd_s1_r, rd_s1_nxt, rd_s2_r, rd_s2_nxt, rd_s3_r, rd_s3_nxt, rd_s4_r, rd_s4_nxt;
  logic wr_s1_r, wr_s1_nxt, wr_s2_r, wr_s2_nxt, wr_s3_r, wr_s3_nxt;
  logic [ADDR_W-1:0] ra1_r, ra1_nxt, ra2_r, ra2_nxt;
  logic [ADDR_W-1:0] wa1_r, wa1_nxt, wa2_r, wa2_nxt, wa3_r, wa3_nxt;
  // write gather buffer, beats 0..2 (beat 3 is taken straight from the odd-edge register)
  logic [BEAT_N-2:0][DQ_W-1:0] wbuf_r, wbuf_nxt;
  logic [BEAT_N-2:0][LANE_N-1:0] mbuf_r, mbuf_nxt;
  // read burst and output registers
  sdbe_burst_t rbuf_r, rbuf_nxt, rburst, wburst;
  sdbe_mask_t wmask;
  logic [DQ_W-1:0] qk_r, qk_nxt, qb_r, qb_nxt, kb_d_r, kb_d_nxt;
  logic [LANE_N-1:0] kb_m_r, kb_m_nxt;
  logic vk_r, vk_nxt, vb_r, vb_nxt, tk_r, tk_nxt, tb_r, tb_nxt;
  logic ecc_off_r, ecc_off_nxt, half_any;
  // array and ecc words
  sdbe_entry_t mem_r [ARR_DEPTH];
  sdbe_entry_t old_ent, new_ent, rd_ent;
  sdbe_words_t wdat, rfix;
  logic [WORD_N-1:0][CHK_W-1:0] wchk;
  logic [WORD_N-1:0] wkeep;
  // system-clock domain
  logic dof_s1_r, dof_r, eo_s1_r, eo_r;
  sdbe_pu_t pu_st_r, pu_st_nxt;
  logic [PU_CNT_W-1:0] pu_cnt_r, pu_cnt_nxt;

  // reset enters each link edge domain through two flip-flops
  always_ff @(posedge k_clk) begin
    krst_s1_r <= rst;
    krst_r <= krst_s1_r;
  end
  always_ff @(posedge kbar_clk) begin
    kbrst_s1_r <= rst;
    kbrst_r <= kbrst_s1_r;
  end

  assign rd_acc = !read_sel_n && !rd_prev_r;
  // repeat write ignored
  // read select is a don't-care when the read was ignored
  assign wr_acc = !write_sel_n && (read_sel_n || rd_prev_r) && !wr_prev_r;

  // write beats: 0 and 2 from primary edges, 1 and 3 from the odd-edge register
  always_comb begin
    wburst[0] = wbuf_r[0];
    wburst[1] = wbuf_r[1];
    wburst[2] = wbuf_r[2];
    wburst[3] = kb_d_r;
    wmask[0] = mbuf_r[0];
    wmask[1] = mbuf_r[1];
    wmask[2] = mbuf_r[2];
    wmask[3] = kb_m_r;
  end

  // merge new bytes over the stored word per lane and half
  always_comb begin
    old_ent = mem_r[wa3_r[ARR_AW-1:0]];
    half_any = 1'b0;
    for (int l = 0; l < LANE_N; l++) begin
      for (int j = 0; j < 2; j++) begin
        wdat[l*2+j][BYTE_W-1:0] = wmask[2*j][l] ? old_ent[l*2+j][BYTE_W-1:0]
                                                : wburst[2*j][l*BYTE_W +: BYTE_W];
        wdat[l*2+j][WORD_W-1:BYTE_W] = wmask[2*j+1][l] ? old_ent[l*2+j][WORD_W-1:BYTE_W]
                                                       : wburst[2*j+1][l*BYTE_W +: BYTE_W];
        wkeep[l*2+j] = wmask[2*j][l] & wmask[2*j+1][l];
        if (wmask[2*j][l] ^ wmask[2*j+1][l]) begin
          half_any = 1'b1;
        end
        new_ent[l*2+j] = wkeep[l*2+j] ? old_ent[l*2+j] : {wchk[l*2+j], wdat[l*2+j]};
      end
    end
  end

  // read entry, corrected words and beat ordering
  always_comb begin
    rd_ent = mem_r[ra2_r[ARR_AW-1:0]];
    for (int b = 0; b < BEAT_N; b++) begin
      for (int l = 0; l < LANE_N; l++) begin
        rburst[b][l*BYTE_W +: BYTE_W] = rfix[l*2 + b/2][(b%2)*BYTE_W +: BYTE_W];
      end
    end
  end

  // one coder per protected word
  for (genvar g = 0; g < WORD_N; g++) begin : g_ecc
    sdbe_ecc_if eb();
    sdbe_ecc_word u_word (
      .eb(eb)
    );
    assign eb.wr_data = wdat[g];
    assign wchk[g] = eb.wr_chk;
    assign eb.rd_data = rd_ent[g][WORD_W-1:0];
    assign eb.rd_chk = rd_ent[g][CW_W-1:WORD_W];
    assign eb.fix_en = !ecc_off_r;
    assign rfix[g] = eb.rd_fix;
  end

  // primary-edge next state
  always_comb begin
    rd_prev_nxt = rd_acc;
    wr_prev_nxt = wr_acc;
    rd_s1_nxt = rd_acc;
    rd_s2_nxt = rd_s1_r;
    rd_s3_nxt = rd_s2_r;
    rd_s4_nxt = rd_s3_r;
    wr_s1_nxt = wr_acc;
    wr_s2_nxt = wr_s1_r;
    wr_s3_nxt = wr_s2_r;
    ra1_nxt = rd_acc ? sync_address_inputs : ra1_r;
    ra2_nxt = ra1_r;
    wa1_nxt = wr_acc ? sync_address_inputs : wa1_r;
    wa2_nxt = wa1_r;
    wa3_nxt = wa2_r;
    wbuf_nxt = wbuf_r;
    mbuf_nxt = mbuf_r;
    if (wr_s1_r) begin
      wbuf_nxt[0] = write_data_in;
      mbuf_nxt[0] = byte_write_mask_n;
    end
    if (wr_s2_r) begin
      wbuf_nxt[1] = kb_d_r;
      mbuf_nxt[1] = kb_m_r;
      wbuf_nxt[2] = write_data_in;
      mbuf_nxt[2] = byte_write_mask_n;
    end
    rbuf_nxt = rd_s2_r ? rburst : rbuf_r;
    qk_nxt = '0;
    vk_nxt = 1'b0;
    if (rd_s3_r) begin
      qk_nxt = rbuf_r[1];
      vk_nxt = 1'b1;
    end else if (rd_s4_r) begin
      qk_nxt = rbuf_r[3];
      vk_nxt = 1'b1;
    end
    tk_nxt = ~tk_r;
    ecc_off_nxt = ecc_off_r | (wr_s3_r & half_any);
    if (krst_r) begin
      rd_prev_nxt = 1'b0;
      wr_prev_nxt = 1'b0;
      rd_s1_nxt = 1'b0;
      rd_s2_nxt = 1'b0;
      rd_s3_nxt = 1'b0;
      rd_s4_nxt = 1'b0;
      wr_s1_nxt = 1'b0;
      wr_s2_nxt = 1'b0;
      wr_s3_nxt = 1'b0;
      qk_nxt = '0;
      vk_nxt = 1'b0;
      tk_nxt = TOGGLE_RST;
      ecc_off_nxt = ECC_OFF_RST;
    end
  end

  // primary-edge registers
  always_ff @(posedge k_clk) begin
    rd_prev_r <= rd_prev_nxt;
    wr_prev_r <= wr_prev_nxt;
    rd_s1_r <= rd_s1_nxt;
    rd_s2_r <= rd_s2_nxt;
    rd_s3_r <= rd_s3_nxt;
    rd_s4_r <= rd_s4_nxt;
    wr_s1_r <= wr_s1_nxt;
    wr_s2_r <= wr_s2_nxt;
    wr_s3_r <= wr_s3_nxt;
    ra1_r <= ra1_nxt;
    ra2_r <= ra2_nxt;
    wa1_r <= wa1_nxt;
    wa2_r <= wa2_nxt;
    wa3_r <= wa3_nxt;
    wbuf_r <= wbuf_nxt;
    mbuf_r <= mbuf_nxt;
    rbuf_r <= rbuf_nxt;
    qk_r <= qk_nxt;
    vk_r <= vk_nxt;
    tk_r <= tk_nxt;
    ecc_off_r <= ecc_off_nxt;
  end

  always_ff @(posedge k_clk) begin
    if (wr_s3_r && !krst_r) begin
      mem_r[wa3_r[ARR_AW-1:0]] <= new_ent;
    end
  end

  // odd-edge next state: capture beats 1/3 and drive read beats 0/2
  always_comb begin
    kb_d_nxt = write_data_in;
    kb_m_nxt = byte_write_mask_n;
    qb_nxt = '0;
    vb_nxt = 1'b0;
    if (rd_s3_r) begin
      qb_nxt = rbuf_r[0];
      vb_nxt = 1'b1;
    end else if (rd_s4_r) begin
      qb_nxt = rbuf_r[2];
      vb_nxt = 1'b1;
    end
    // copy of the primary toggle marks which edge fired last
    tb_nxt = tk_r;
    if (kbrst_r) begin
      qb_nxt = '0;
      vb_nxt = 1'b0;
      tb_nxt = TOGGLE_RST;
    end
  end

  // odd-edge registers
  always_ff @(posedge kbar_clk) begin
    kb_d_r <= kb_d_nxt;
    kb_m_r <= kb_m_nxt;
    qb_r <= qb_nxt;
    vb_r <= vb_nxt;
    tb_r <= tb_nxt;
  end

  // double-rate output: toggles differ right after a primary edge
  assign read_data_out = (tk_r != tb_r) ? qk_r : qb_r;
  assign read_output_valid = (tk_r != tb_r) ? vk_r : vb_r;
  assign echo_clock_out = k_clk;
  assign echo_clock_out_n = kbar_clk;

  // level synchronisers into the system clock
  always_ff @(posedge clk) begin
    dof_s1_r <= dll_off_n;
    dof_r <= dof_s1_r;
    eo_s1_r <= ecc_off_r;
    eo_r <= eo_s1_r;
  end

  always_comb begin
    pu_st_nxt = pu_st_r;
    pu_cnt_nxt = pu_cnt_r + PU_CNT_W'(1);
    unique case (pu_st_r)
      PU_IMP: begin
        if (pu_cnt_r == PU_CNT_W'(IMP_WAIT - 1)) begin
          pu_st_nxt = PU_LOCK;
          pu_cnt_nxt = '0;
        end
      end
      PU_LOCK: begin
        if (!dof_r) begin
          pu_st_nxt = PU_DONE;
        end else if (pu_cnt_r == PU_CNT_W'(DLL_WAIT - 1)) begin
          pu_st_nxt = PU_DONE;
        end
      end
      PU_DONE: begin
        pu_cnt_nxt = pu_cnt_r;
      end
      default: begin
        pu_st_nxt = PU_IMP;
        pu_cnt_nxt = '0;
      end
    endcase
    if (rst) begin
      pu_st_nxt = PU_IMP;
      pu_cnt_nxt = '0;
    end
  end

  always_ff @(posedge clk) begin
    pu_st_r <= pu_st_nxt;
    pu_cnt_r <= pu_cnt_nxt;
  end

  assign dll_enabled = dof_r;
  assign ecc_active = !eo_r;
  assign powerup_done = (pu_st_r == PU_DONE);
endmodule : sdbe_port

// file: test/sdbe_port_checker.sv
`timescale 1ns/10ps
module sdbe_port_checker #(
  parameter int unsigned IMP_WAIT = 20,
  parameter int unsigned DLL_WAIT = 10
) (
  // clocks and reset
  input wire logic clk,
  input wire logic rst,
  input wire logic k_clk,
  input wire logic kbar_clk,
  // command and write data
  input wire logic [sdbe_pkg::ADDR_W-1:0] sync_address_inputs,
  input wire logic read_sel_n,
  input wire logic write_sel_n,
  input wire logic [sdbe_pkg::DQ_W-1:0] write_data_in,
  input wire logic [sdbe_pkg::LANE_N-1:0] byte_write_mask_n,
  // read side and status
  input wire logic [sdbe_pkg::DQ_W-1:0] read_data_out,
  input wire logic read_output_valid,
  input wire logic echo_clock_out,
  input wire logic echo_clock_out_n,
  input wire logic dll_off_n,
  input wire logic dll_enabled,
  input wire logic ecc_active,
  input wire logic powerup_done
);
  import sdbe_pkg::*;
  logic rd_prev_r, rd_prev_nxt, rd_acc;
  logic [15:0] cnt_r, cnt_nxt;
  // read taken: select low with no read taken one edge before
  always_comb begin
    rd_acc = !read_sel_n && !rd_prev_r;
    rd_prev_nxt = rst ? 1'b0 : rd_acc;
  end
  always_ff @(posedge k_clk) begin
    rd_prev_r <= rd_prev_nxt;
  end
  // clk cycles since reset release, saturating
  always_comb cnt_nxt = rst ? 16'h0 : cnt_r + 16'(cnt_r != 16'hffff);
  always_ff @(posedge clk) begin
    cnt_r <= cnt_nxt;
  end
  echo_pass_a: assert property (@(posedge clk) disable iff (rst)
    echo_clock_out == k_clk && echo_clock_out_n == kbar_clk) else $error("echo clock mismatch");
  dll_follow_a: assert property (@(posedge clk) disable iff (rst)
    $changed(dll_off_n) |-> ##[1:3] dll_enabled == dll_off_n) else $error("dll state late");
  pu_early_a: assert property (@(posedge clk) disable iff (rst)
    $rose(powerup_done) |-> cnt_r + 16'h1 >= (dll_enabled ? IMP_WAIT + DLL_WAIT : IMP_WAIT))
    else $error("powerup done too early");
  pu_late_a: assert property (@(posedge clk) disable iff (rst)
    cnt_r == IMP_WAIT + DLL_WAIT + 3 |-> powerup_done) else $error("powerup done too late");
  ecc_sticky_a: assert property (@(posedge clk) disable iff (rst)
    !$rose(ecc_active)) else $error("ecc came back without reset");
  rd_track_a: assert property (@(posedge k_clk) disable iff (rst)
    read_output_valid == ($past(rd_acc, 3) || $past(rd_acc, 4))) else $error("valid mismatch");
  rd_burst_a: assert property (@(posedge k_clk) disable iff (rst)
    rd_acc |-> ##3 read_output_valid [*2]) else $error("read burst short");
  rd_idle_a: assert property (@(posedge k_clk) disable iff (rst)
    !read_output_valid |-> read_data_out == '0) else $error("idle data not zero");
endmodule : sdbe_port_checker

bind sdbe_port sdbe_port_checker #(.IMP_WAIT(IMP_WAIT), .DLL_WAIT(DLL_WAIT)) chk_i (
  .clk(clk), .rst(rst), .k_clk(k_clk), .kbar_clk(kbar_clk),
  .sync_address_inputs(sync_address_inputs), .read_sel_n(read_sel_n),
  .write_sel_n(write_sel_n), .write_data_in(write_data_in),
  .byte_write_mask_n(byte_write_mask_n), .read_data_out(read_data_out),
  .read_output_valid(read_output_valid), .echo_clock_out(echo_clock_out),
  .echo_clock_out_n(echo_clock_out_n), .dll_off_n(dll_off_n), .dll_enabled(dll_enabled),
  .ecc_active(ecc_active), .powerup_done(powerup_done));

// file: test/sdbe_ctrl_model.sv
`timescale 1ns/10ps
module sdbe_ctrl_model (
  // link clocks
  output logic k_clk,
  output logic kbar_clk,
  // command and write data
  output logic [sdbe_pkg::ADDR_W-1:0] addr,
  output logic rd_n,
  output logic wr_n,
  output logic [sdbe_pkg::DQ_W-1:0] wdata,
  output logic [sdbe_pkg::LANE_N-1:0] wmask_n,
  // read data back
  input wire logic [sdbe_pkg::DQ_W-1:0] rdata,
  input wire logic rvalid
);
  import sdbe_pkg::*;
  // free-running link clocks, offset from the system clock
  initial begin
    {addr, rd_n, wr_n, wdata, wmask_n} = {20'h0, 2'h3, 18'h0, 2'h0};
    k_clk = 1'b0;
    #2.7;
    forever #6 k_clk = ~k_clk;
  end
  assign kbar_clk = ~k_clk;
  // launch just after a k edge
  task automatic kstep();
    @(posedge k_clk);
    #1;
  endtask : kstep
  // four beats on alternating edges, halves full or aborted unless told
  task automatic wr(logic [ADDR_W-1:0] a, sdbe_burst_t d, sdbe_mask_t m, int hold);
    kstep();
    addr = a;
    wr_n = 1'b0;
    kstep();
    wr_n = (hold != 2);
    addr = (hold == 2) ? a ^ 20'h1 : ~a;
    for (int b = 0; b < BEAT_N; b++) begin
      wdata = d[b];
      wmask_n = m[b];
      if (b % 2 == 0) @(posedge k_clk);
      else @(posedge kbar_clk);
      #1;
      wr_n = 1'b1;
    end
    wdata = ~wdata;
    wmask_n = ~wmask_n;
  endtask : wr
  // read command, beats taken mid-half-cycle, then the trailing valid
  task automatic rd(logic [ADDR_W-1:0] a, int hold, logic wl, output sdbe_burst_t q,
                    output logic tail);
    kstep();
    addr = a;
    rd_n = 1'b0;
    wr_n = ~wl;
    wmask_n = '0; // masks open, so a wrongly taken write would land
    kstep();
    wr_n = 1'b1;
    rd_n = (hold != 2);
    addr = ~a;
    kstep();
    rd_n = 1'b1;
    @(posedge k_clk);
    for (int b = 0; b < BEAT_N; b++) begin
      if (b % 2 == 0) @(posedge kbar_clk);
      else @(posedge k_clk);
      #2;
      q[b] = (rvalid === 1'b1) ? rdata : 'x;
    end
    @(posedge kbar_clk);
    #2;
    tail = rvalid;
  endtask : rd
endmodule : sdbe_ctrl_model

// file: test/tb_sdbe_port.sv
`timescale 1ns/10ps
module tb_sdbe_port;
  import sdbe_pkg::*;
  localparam int unsigned IMP_T = 20;
  localparam int unsigned DLL_T = 10;
  localparam sdbe_burst_t B1 = 72'h123456789abcdef012;
  localparam sdbe_burst_t B2 = 72'hfedcba9876543210fe;
  localparam sdbe_burst_t B3 = 72'h5a5a5a5a5a5a5a5a5a;
  // system side
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic dll_off_n = 1'b1;
  logic dll_en, ecc_on, pu_done, ecq, ecqn;
  // link side
  logic k_clk, kbar_clk, rd_n, wr_n, rvalid;
  logic [ADDR_W-1:0] addr;
  logic [DQ_W-1:0] wdata, rdata;
  logic [LANE_N-1:0] wmask_n;
  int n_fail = 0;
  int tests_run = 0;
  int cyc = 0;
  always #12.5 clk = ~clk;
  sdbe_port #(.IMP_WAIT(IMP_T), .DLL_WAIT(DLL_T)) sdbe_port_i (
    .clk(clk), .rst(rst), .k_clk(k_clk), .kbar_clk(kbar_clk), .sync_address_inputs(addr),
    .read_sel_n(rd_n), .write_sel_n(wr_n), .write_data_in(wdata), .byte_write_mask_n(wmask_n),
    .read_data_out(rdata), .read_output_valid(rvalid), .echo_clock_out(ecq),
    .echo_clock_out_n(ecqn), .dll_off_n(dll_off_n), .dll_enabled(dll_en),
    .ecc_active(ecc_on), .powerup_done(pu_done));
  sdbe_ctrl_model sdbe_ctrl_model_i (
    .k_clk(k_clk), .kbar_clk(kbar_clk), .addr(addr), .rd_n(rd_n), .wr_n(wr_n),
    .wdata(wdata), .wmask_n(wmask_n), .rdata(rdata), .rvalid(rvalid));
  // compare and count
  task automatic chk(string nm, logic [71:0] e, logic [71:0] g);
    tests_run++;
    if (g !== e) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // expected burst after a masked write over old contents
  function automatic sdbe_burst_t merge(sdbe_burst_t o, sdbe_burst_t n, sdbe_mask_t m);
    sdbe_burst_t r;
    r = o;
    for (int b = 0; b < BEAT_N; b++)
      for (int l = 0; l < LANE_N; l++)
        if (!m[b][l]) r[b][l*BYTE_W +: BYTE_W] = n[b][l*BYTE_W +: BYTE_W];
    return r;
  endfunction : merge
  task automatic wr(logic [ADDR_W-1:0] a, sdbe_burst_t d, sdbe_mask_t m, int hold);
    sdbe_ctrl_model_i.wr(a, d, m, hold);
  endtask : wr
  // read one burst, check its beats and the drop of valid after it
  task automatic rdchk(string nm, logic [ADDR_W-1:0] a, int hold, logic wl, sdbe_burst_t e);
    sdbe_burst_t q;
    logic tail;
    sdbe_ctrl_model_i.rd(a, hold, wl, q, tail);
    chk(nm, e, q);
    chk("valid tail", 0, tail);
  endtask : rdchk
  // reset, then count cycles until power-up completes
  task automatic do_reset(output int n);
    @(posedge clk);
    #1 rst = 1'b1;
    repeat (4) @(posedge clk);
    #1 rst = 1'b0;
    n = 0;
    while (pu_done !== 1'b1 && n < 200) begin
      @(posedge clk);
      #1 n++;
    end
  endtask : do_reset
  task automatic t_power();
    int n;
    do_reset(n);
    chk("powerup", 1, n >= IMP_T + DLL_T - 1 && n <= IMP_T + DLL_T + 3);
    chk("dll on", 1, dll_en);
    chk("ecc on", 1, ecc_on);
    $display("test power done");
  endtask : t_power
  task automatic t_full();
    wr(4, B1, '0, 1);
    wr(5, B2, '0, 1);
    rdchk("full a", 4, 1, 0, B1);
    rdchk("full b", 5, 1, 0, B2);
    $display("test full done");
  endtask : t_full
  task automatic t_mask();
    wr(4, B3, 8'h5a, 1);
    rdchk("abort", 4, 1, 0, merge(B1, B3, 8'h5a));
    repeat (4) @(posedge clk);
    chk("ecc kept", 1, ecc_on);
    $display("test mask done");
  endtask : t_mask
  task automatic t_back();
    rdchk("read twice", 4, 2, 0, merge(B1, B3, 8'h5a));
    wr(4, B1, '0, 2);
    rdchk("write twice", 5, 1, 0, B2);
    rdchk("first write", 4, 1, 0, B1);
    $display("test back done");
  endtask : t_back
  task automatic t_both();
    rdchk("read wins", 5, 1, 1, B2);
    rdchk("no write", 5, 1, 0, B2);
    $display("test both done");
  endtask : t_both
  task automatic t_half();
    wr(6, B1, '0, 1);
    wr(6, B3, 8'hfe, 1);
    repeat (6) @(posedge clk);
    chk("ecc off", 0, ecc_on);
    rdchk("half one", 6, 1, 0, merge(B1, B3, 8'hfe));
    wr(7, B2, '0, 1);
    wr(7, B1, 8'hfb, 1);
    rdchk("half two", 7, 1, 0, merge(B2, B1, 8'hfb));
    $display("test half done");
  endtask : t_half
  task automatic t_dll();
    int n;
    @(posedge clk);
    #1 dll_off_n = 1'b0;
    repeat (4) @(posedge clk);
    chk("dll off", 0, dll_en);
    do_reset(n);
    chk("no lock wait", 1, n >= IMP_T - 1 && n <= IMP_T + 3);
    chk("ecc back", 1, ecc_on);
    #1 dll_off_n = 1'b1;
    repeat (4) @(posedge clk);
    chk("dll back", 1, dll_en);
    $display("test dll done");
  endtask : t_dll
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : end_of_test
  // cycle ceiling against a hang
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      n_fail++;
      end_of_test();
    end
  end
  initial begin
    t_power();
    t_full();
    t_mask();
    t_back();
    t_both();
    t_half();
    t_dll();
    end_of_test();
  end
endmodule : tb_sdbe_port
